// ---- rtl/asop_pipeline.sv ----
// Digital side of a 10-bit subranging converter: correction and output pipeline.
// Assumes quantizer codes and the strobe are synchronous to I_CLK_SYS.
// Function
// - Each rising strobe edge captures a new sample held for its whole conversion.
// - Sample taken at strobe edge N appears after strobe edge N+3.
// - Output bus changes only on a rising strobe edge.
// - Result is 10-bit two's complement, bit 9 MSB, midscale input gives zero.
// - Range flag high when sample above 1FFh or below 200h, else low.
// - Out-of-range results clamp to 1FFh or 200h instead of wrapping.
// - Five-bit coarse and six-bit fine codes merge into corrected ten-bit result.
`timescale 1ns/1ps
`default_nettype none
module asop_pipeline
(
   input wire logic I_CLK_SYS,
   input wire logic I_ARST_N,
   input wire logic I_STROBE_P,
   input wire logic I_STROBE_N,
   input wire logic [asop_pkg::COARSE_W-1:0] I_COARSE,
   input wire logic [asop_pkg::FINE_W-1:0] I_FINE,
   input wire logic I_OVER,
   input wire logic I_UNDER,
   output logic [asop_pkg::RESULT_W-1:0] O_RESULT_BITS,
   output logic O_RANGE
);
   logic rst_s1_q;
   logic rst_n_q;
   logic strobe_w;
   logic strobe_q;
   logic edge_w;
   logic [asop_pkg::RAW_W:0] sum_w;
   logic [asop_pkg::RAW_W-1:0] raw_w;
   logic [asop_pkg::RESULT_W-1:0] corr_w;
   logic corr_range_w;
   logic [asop_pkg::RESULT_W-1:0] word_q [asop_pkg::PIPE_DEPTH-1];
   logic range_q [asop_pkg::PIPE_DEPTH-1];
   logic [asop_pkg::RESULT_W-1:0] samp_word_q;
   logic samp_range_q;
   logic [1:0] edge_cnt_q;
   logic [1:0] fill_q;
   logic [asop_pkg::RESULT_W-1:0] tag_word_q [asop_pkg::PIPE_DEPTH+1];
   logic tag_range_q [asop_pkg::PIPE_DEPTH+1];

   // Clamps out-of-range samples to full scale and flags them instead of wrapping.
   function automatic logic [asop_pkg::RESULT_W:0] clamp_code
   (
      input logic over,
      input logic under,
      input logic [asop_pkg::RAW_W:0] sum
   );
      if (over)
         return {1'b1, asop_pkg::CODE_POS_FS};
      else if (under)
         return {1'b1, asop_pkg::CODE_NEG_FS};
      else if (sum[asop_pkg::RAW_W])
         return {1'b1, asop_pkg::CODE_NEG_FS};
      else if (sum[asop_pkg::RAW_W-1:0] > asop_pkg::RAW_TOP)
         return {1'b1, asop_pkg::CODE_POS_FS};
      else
         return {1'b0, sum[asop_pkg::RESULT_W-1:0]
            ^ asop_pkg::RAW_MIDSCALE[asop_pkg::RESULT_W-1:0]};
   endfunction

   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end

   // The strobe is high while the true side is above the complement.
   assign strobe_w = I_STROBE_P & ~I_STROBE_N;

   always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
   begin
      if (!rst_n_q)
         strobe_q <= 1'b0;
      else
         strobe_q <= strobe_w;
   end

   assign edge_w = strobe_w & ~strobe_q;

   // The merged code carries a sign bit, so overflow and underflow stay apart.
   assign sum_w = {2'b00, I_COARSE, {(asop_pkg::FINE_W-1){1'b0}}}
      + {{(asop_pkg::RAW_W+1-asop_pkg::FINE_W){1'b0}}, I_FINE}
      - {1'b0, asop_pkg::FINE_OFFSET};
   assign raw_w = sum_w[asop_pkg::RAW_W-1:0];
   assign {corr_range_w, corr_w} = clamp_code(I_OVER, I_UNDER, sum_w);

   // Sample captured on strobe edge and held until the next one
   always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         samp_word_q <= asop_pkg::CODE_ZERO;
         samp_range_q <= 1'b0;
      end
      else if (edge_w)
      begin
         samp_word_q <= corr_w;
         samp_range_q <= corr_range_w;
      end
   end

   // Stage zero takes the held sample on each strobe edge.
   always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         word_q[0] <= asop_pkg::CODE_ZERO;
         range_q[0] <= 1'b0;
      end
      else if (edge_w)
      begin
         word_q[0] <= samp_word_q;
         range_q[0] <= samp_range_q;
      end
   end

   // Each further stage passes its word on by one strobe edge.
   for (genvar g = 1; g < asop_pkg::PIPE_DEPTH-1; g++)
   begin : g_stage
      always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
      begin
         if (!rst_n_q)
         begin
            word_q[g] <= asop_pkg::CODE_ZERO;
            range_q[g] <= 1'b0;
         end
         else if (edge_w)
         begin
            word_q[g] <= word_q[g-1];
            range_q[g] <= range_q[g-1];
         end
      end
   end

   // The output register loads the last stage, so the bus moves only on strobe edges.
   always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         O_RESULT_BITS <= asop_pkg::CODE_ZERO;
         O_RANGE <= 1'b0;
      end
      else if (edge_w)
      begin
         O_RESULT_BITS <= word_q[asop_pkg::PIPE_DEPTH-2];
         O_RANGE <= range_q[asop_pkg::PIPE_DEPTH-2];
      end
   end

   // Edge index and fill level for the latency check.
   always_ff @(posedge I_CLK_SYS or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         edge_cnt_q <= 2'h0;
         fill_q <= 2'h0;
      end
      else if (edge_w)
      begin
         edge_cnt_q <= edge_cnt_q + 2'h1;
         if (fill_q != 2'(asop_pkg::PIPE_DEPTH))
            fill_q <= fill_q + 2'h1;
      end
   end

   // Each strobe edge files its corrected sample under its edge index.
   always_ff @(posedge I_CLK_SYS)
   begin
      if (edge_w)
      begin
         tag_word_q[edge_cnt_q] <= corr_w;
         tag_range_q[edge_cnt_q] <= corr_range_w;
      end
   end

   out_stable_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      !$past(edge_w) |-> $stable(O_RESULT_BITS) && $stable(O_RANGE))
      else $error("Output changed without a strobe edge.");

   clamp_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      O_RANGE |-> (O_RESULT_BITS == asop_pkg::CODE_POS_FS
      || O_RESULT_BITS == asop_pkg::CODE_NEG_FS))
      else $error("Out-of-range word not clamped.");

   over_code_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && I_OVER |=> samp_word_q == asop_pkg::CODE_POS_FS && samp_range_q)
      else $error("Overrange sample not flagged at positive full scale.");

   under_code_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && I_UNDER && !I_OVER |=> samp_word_q == asop_pkg::CODE_NEG_FS)
      else $error("Underrange sample not at negative full scale.");

   zero_code_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && !I_OVER && !I_UNDER && raw_w == asop_pkg::RAW_MIDSCALE
      |=> samp_word_q == asop_pkg::CODE_ZERO && !samp_range_q)
      else $error("Midscale did not give zero code.");

   merge_code_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && !I_OVER && !I_UNDER && I_COARSE == 5'h10 && I_FINE == 6'h10
      |=> samp_word_q == asop_pkg::CODE_ZERO)
      else $error("Coarse and fine merge wrong.");

   hold_sample_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      !edge_w |=> $stable(samp_word_q) && $stable(samp_range_q))
      else $error("Held sample changed between strobe edges.");

   pipe_latency_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && fill_q == 2'(asop_pkg::PIPE_DEPTH)
      |=> O_RESULT_BITS == tag_word_q[edge_cnt_q]
      && O_RANGE == tag_range_q[edge_cnt_q])
      else $error("Output is not the sample from three strobe edges before.");

   fill_zero_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && fill_q != 2'(asop_pkg::PIPE_DEPTH)
      |=> O_RESULT_BITS == asop_pkg::CODE_ZERO && !O_RANGE)
      else $error("Output left its reset value before the pipeline filled.");

   range_low_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && !I_OVER && !I_UNDER && I_COARSE == 5'h10 |=> !samp_range_q)
      else $error("In-range sample flagged out of range.");

   sum_over_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && !I_OVER && !I_UNDER && I_COARSE == '1 && I_FINE == '1
      |=> samp_word_q == asop_pkg::CODE_POS_FS && samp_range_q)
      else $error("Merged code above full scale did not clamp high.");

   sum_under_a: assert property (@(posedge I_CLK_SYS) disable iff (!rst_n_q)
      edge_w && !I_OVER && !I_UNDER && I_COARSE == '0 && I_FINE == '0
      |=> samp_word_q == asop_pkg::CODE_NEG_FS && samp_range_q)
      else $error("Merged code below full scale did not clamp low.");
endmodule
`default_nettype wire

// ---- shared/asop_pkg.sv ----
// Package for the converter output pipeline: widths, codes and latency.
// Assumes a single system clock domain and no bus access.
package asop_pkg;
   localparam int unsigned RESULT_W = 10;
   localparam int unsigned COARSE_W = 5;
   localparam int unsigned FINE_W = 6;
   localparam int unsigned RAW_W = 11;
   localparam int unsigned PIPE_DEPTH = 3;
   localparam logic [RESULT_W-1:0] CODE_POS_FS = 10'h1FF;
   localparam logic [RESULT_W-1:0] CODE_NEG_FS = 10'h200;
   localparam logic [RESULT_W-1:0] CODE_ZERO = 10'h000;
   localparam logic [RAW_W-1:0] FINE_OFFSET = 11'h010;
   localparam logic [RAW_W-1:0] RAW_MIDSCALE = 11'h200;
   localparam logic [RAW_W-1:0] RAW_TOP = 11'h3FF;
endpackage

// ---- verification/asop_capture.sv ----
// Capture-side model: counts strobe edges, flags data valid from the fourth edge after reset or after a stopped strobe.
// Assumes the strobe level is sampled with the system clock.
`timescale 1ns/1ps
`default_nettype none
module asop_capture
(
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_strobe,
   output logic o_valid
);
   // A strobe that stays low this many clocks counts as stopped.
   localparam logic [3:0] IDLE_LIMIT = 4'h8;
   logic stb_q;
   logic [2:0] cnt_q;
   logic [3:0] idle_q;
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         stb_q <= 1'b0;
         cnt_q <= 3'h0;
         idle_q <= 4'h0;
      end
      else
      begin
         stb_q <= i_strobe;
         if (i_strobe)
            idle_q <= 4'h0;
         else if (idle_q != IDLE_LIMIT)
            idle_q <= idle_q + 4'h1;
         if (i_strobe && !stb_q && idle_q == IDLE_LIMIT)
            cnt_q <= 3'h1;
         else if (i_strobe && !stb_q && cnt_q != 3'h4)
            cnt_q <= cnt_q + 3'h1;
      end
   end
   assign o_valid = (cnt_q == 3'h4);
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Bench: random codes, queue model of the pipeline, capture partner.
// Assumes the package and the pipeline are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk = 1'b0, arst_n = 1'b0, p = 1'b0, n = 1'b1, ov = 1'b0, un = 1'b0, vld;
   logic [asop_pkg::COARSE_W-1:0] co = 5'h00;
   logic [asop_pkg::FINE_W-1:0] fi = 6'h00;
   logic [asop_pkg::RESULT_W-1:0] res;
   logic rng;
   logic [10:0] last;
   int err_count = 0, compares = 0, seed = 32'h8b14, raw, i, r;
   int q[$];
   asop_pipeline asop_pipeline_i (.I_CLK_SYS(clk), .I_ARST_N(arst_n), .I_STROBE_P(p),
      .I_STROBE_N(n), .I_COARSE(co), .I_FINE(fi), .I_OVER(ov), .I_UNDER(un),
      .O_RESULT_BITS(res), .O_RANGE(rng));
   asop_capture asop_capture_i (.i_clk(clk), .i_arst_n(arst_n), .i_strobe(p & ~n),
      .o_valid(vld));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [10:0] got, input logic [10:0] want);
      compares++;
      if (got !== want)
      begin
         err_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d errors %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(negedge clk);
      arst_n = 1'b1;
      repeat (4) @(negedge clk);
      for (i = 0; i < 400; i++)
      begin
         if (i == 200) repeat (20) @(negedge clk);
         if (i > 0) check({rng, res}, last);
         r = $random(seed);
         co = (i == 0) ? 5'h10 : (i == 1) ? 5'h1F : (i == 2) ? 5'h00 : r[4:0];
         fi = (i == 0) ? 6'h10 : (i == 1) ? 6'h3F : (i == 2) ? 6'h00 : r[10:5];
         ov = (i > 2 && r[15:12] == 4'h0);
         un = (i > 2 && r[15:12] == 4'h1);
         raw = int'(co) * 32 + int'(fi) - 16;
         if (ov || (!un && raw > 1023))
            q.push_back(32'h5FF);
         else if (un || raw < 0)
            q.push_back(32'h600);
         else
            q.push_back(raw ^ 32'h200);
         p = 1'b1;
         n = 1'b0;
         @(negedge clk);
         p = 1'b0;
         n = (i < 200);
         if (i < 3) check({rng, res}, 11'h000);
         else check({rng, res}, 11'(q.pop_front()));
         check({10'h000, vld}, {10'h000, i >= 3 && (i < 200 || i >= 203)});
         last = {rng, res};
         repeat (1 + r[17:16]) @(negedge clk);
      end
      print_verdict();
   end
   initial
   begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
